// ### hdl/are_defs.svh
// Register offsets, field positions, reset values and timing counts of the serial receiver
`ifndef ARE_DEFS_SVH
`define ARE_DEFS_SVH

`define ARE_OFF_TXSC      8'h00
`define ARE_OFF_RCSC      8'h04
`define ARE_OFF_RXDATA    8'h08
`define ARE_OFF_IRQ       8'h0C

`define ARE_TX_CLOCK_SOURCE_SELECT       7
`define ARE_TX_TX9        6
`define ARE_TX_TRANSMIT_ENABLE       5
`define ARE_TX_SYNC       4
`define ARE_TX_BRK        3
`define ARE_TX_HIGH_BAUD_SELECT       2
`define ARE_TX_TX_SHIFT_EMPTY       1
`define ARE_TX_TX_NINTH_BIT       0

`define ARE_RC_SERIAL_PORT_ENABLE       7
`define ARE_RC_RX9        6
`define ARE_RC_SINGLE_RX_ENABLE       5
`define ARE_RC_CONTINUOUS_RX_ENABLE       4
`define ARE_RC_ADDR_DETECT_ENABLE      3
`define ARE_RC_FRAME_ERR_FLAG       2
`define ARE_RC_OVERRUN_ERR_FLAG       1
`define ARE_RC_RX_NINTH_BIT       0

`define ARE_IRQ_FLAG      0
`define ARE_IRQ_EN        1

`define ARE_TXSC_RST      8'h02
`define ARE_RCSC_RST      8'h00
`define ARE_IRQ_RST       8'h00

`define ARE_OVS_LAST      4'hF
`define ARE_OVS_HALF      4'h7
`define ARE_OVS_MAJ0      4'hD
`define ARE_BRK_BITS      4'hD
`define ARE_LOW_SPEED_MUL 4
`define ARE_FIFO_DEPTH    2

`endif

// ### hdl/are_pkg.sv
// Types shared by the serial receiver
package are_pkg;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} are_rx_state_e;
    typedef enum logic [1:0] {TX_IDLE, TX_BRK, TX_STOPBIT} are_tx_state_e;
    typedef logic [9:0] are_entry_t;
endpackage : are_pkg

// ### hdl/are_serial_rx.sv
// Asynchronous serial receiver with error flags, address detect and break sender
//
// Operation
// [R1] Each FIFO character carries its own framing flag (stop bit missing).
// [R2] Visible framing bit belongs to the oldest unread character; read-only.
// [R3] Framing errors never stop reception and need no clearing.
// [R4] Reading receive data pops; next character and its flag become visible.
// [R5] Port disable clears framing status; dropping receive enable keeps it.
// [R6] Framing error raises no interrupt; only the received-character flag does.
// [R7] FIFO holds two; a third complete character sets overrun.
// [R8] During overrun stored characters stay readable, nothing new is accepted.
// [R9] Overrun clears only by dropping receive enable or disabling the port.
// [R10] Nine-bit select shifts nine data bits per character.
// [R11] Ninth-bit status shows MSB of oldest character; software reads it first.
// [R12] Address detect bit enables detection, only with nine-bit reception.
// [R13] With address detect, only ninth-bit-one characters enter FIFO.
// [R14] Software clears address detect after its address, sets it after message.
// [R15] Receive flag set on every FIFO load; interrupt requested if enabled.
// [R16] Software reads status before data and clears overrun via receive enable.
// [R17] Mode bit four selects synchronous when one, asynchronous when zero.
// [R18] Break request sends a break; hardware clears it on completion.
// [R19] Shift-empty status is read-only, one when empty, resets to one.
// [R20] High-baud bit picks speed in asynchronous mode, ignored in synchronous.
// [R21] Synchronous clock-source bit selects master clock when one.
// [R22] In synchronous mode receive enables override transmit enable.
// [R23] Stop position sampling zero sets framing flag, else clears it.
// [R24] Port disable holds unit in reset; enable hands pins to the port.
// [R25] Receive status bit layout: 7,6,3,2,1,0 as documented fields.
// [R26] Port disable empties the FIFO with all stored flags.
`timescale 1ns/1ps
`include "are_defs.svh"

module are_serial_rx
    import are_pkg::*;
#(
    parameter int unsigned BAUD_DIV = 13
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_pin,
    output logic             tx_out,
    output logic             tx_oe_n,
    output logic             pins_to_port,
    output logic             sync_mode,
    output logic             clk_master_sel,
    output logic             tx_enable_eff,
    output logic             rx_irq
);

    localparam logic [15:0] DIV_HI = 16'(BAUD_DIV - 1);
    localparam logic [15:0] DIV_LO = 16'(BAUD_DIV * `ARE_LOW_SPEED_MUL - 1);

    logic        clock_source_select_ff, tx9_ff, transmit_enable_ff, sync_ff, brk_ff, high_baud_select_ff, tx_ninth_bit_ff;
    logic        serial_port_enable_ff, rx9_ff, single_rx_enable_ff, continuous_rx_enable_ff, addr_detect_enable_ff, overrun_err_flag_ff, rx_char_irq_enable_ff;
    logic        pready_ff, pslverr_ff;
    logic [31:0] prdata_ff;
    logic        acc_done, wr_hit, addr_hit, rd_pop;
    logic [7:0]  txsc_rd, rcsc_rd, irq_rd, rd_mux;
    logic [15:0] div_cnt_ff;
    logic        tick;
    logic        rx_s1_ff, rx_s2_ff, rx_s3_ff, rx_lvl_ff;
    are_rx_state_e rx_st_ff;
    logic [3:0]  os_cnt_ff, bit_idx_ff;
    logic [1:0]  ones_ff;
    logic [8:0]  shreg_ff;
    logic        bit_val, stop_done, rx_go, accept, push, ovr_set;
    logic [8:0]  char_new;
    are_entry_t  mem_ff [`ARE_FIFO_DEPTH];
    logic        wr_ptr_ff, rd_ptr_ff;
    logic [1:0]  cnt_ff;
    are_entry_t  top;
    logic        frame_err_flag, rx_ninth_bit, rx_char_flag;
    are_tx_state_e tx_st_ff;
    logic [3:0]  tos_ff, tbits_ff;
    logic        brk_done;
    logic        urst;

    assign urst = !serial_port_enable_ff;                                               // [R24]

    // APB: one wait state so read data comes from flip-flops
    assign acc_done = psel && penable && pready_ff;
    assign addr_hit = (paddr == `ARE_OFF_TXSC) || (paddr == `ARE_OFF_RCSC) ||
                      (paddr == `ARE_OFF_RXDATA) || (paddr == `ARE_OFF_IRQ);
    assign wr_hit   = acc_done && pwrite;
    assign rd_pop   = acc_done && !pwrite && (paddr == `ARE_OFF_RXDATA) &&
                      (cnt_ff != 2'd0);                                   // [R4]

    assign top            = mem_ff[rd_ptr_ff];
    assign rx_char_flag   = (cnt_ff != 2'd0);                             // [R15]
    assign frame_err_flag = rx_char_flag && top[9];                       // [R2]
    assign rx_ninth_bit   = rx_char_flag && top[8];                       // [R11]

    always_comb
    begin
        txsc_rd = {clock_source_select_ff, tx9_ff, transmit_enable_ff, sync_ff, brk_ff, high_baud_select_ff,
                   (tx_st_ff == TX_IDLE), tx_ninth_bit_ff};                       // [R19]
        rcsc_rd = {serial_port_enable_ff, rx9_ff, single_rx_enable_ff, continuous_rx_enable_ff, addr_detect_enable_ff,
                   frame_err_flag, overrun_err_flag_ff, rx_ninth_bit};                // [R25]
        irq_rd  = {6'h00, rx_char_irq_enable_ff, rx_char_flag};
        case (paddr)
            `ARE_OFF_TXSC:   rd_mux = txsc_rd;
            `ARE_OFF_RCSC:   rd_mux = rcsc_rd;
            `ARE_OFF_RXDATA: rd_mux = top[7:0];
            `ARE_OFF_IRQ:    rd_mux = irq_rd;
            default:         rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end
        else if (psel && penable && !pready_ff)
        begin
            pready_ff  <= 1'b1;
            pslverr_ff <= !addr_hit;
            prdata_ff  <= {24'h00_0000, rd_mux};
        end
        else
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end

    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;
    assign prdata  = prdata_ff;

    // Transmit status/control; break bit also cleared by hardware
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {clock_source_select_ff, tx9_ff, transmit_enable_ff, sync_ff} <= 4'h0;
            {high_baud_select_ff, tx_ninth_bit_ff}                  <= 2'h0;
            brk_ff                              <= 1'b0;
        end
        else if (wr_hit && paddr == `ARE_OFF_TXSC)
        begin
            clock_source_select_ff <= pwdata[`ARE_TX_CLOCK_SOURCE_SELECT];
            tx9_ff  <= pwdata[`ARE_TX_TX9];
            transmit_enable_ff <= pwdata[`ARE_TX_TRANSMIT_ENABLE];
            sync_ff <= pwdata[`ARE_TX_SYNC];                              // [R17]
            brk_ff  <= pwdata[`ARE_TX_BRK];
            high_baud_select_ff <= pwdata[`ARE_TX_HIGH_BAUD_SELECT];
            tx_ninth_bit_ff <= pwdata[`ARE_TX_TX_NINTH_BIT];
        end
        else if (brk_done || urst)
        begin
            brk_ff <= 1'b0;                                               // [R18]
        end
    end

    // Receive status/control and interrupt enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {serial_port_enable_ff, rx9_ff, single_rx_enable_ff, continuous_rx_enable_ff, addr_detect_enable_ff} <= 5'h00;
            rx_char_irq_enable_ff                                       <= 1'b0;
        end
        else
        begin
            if (wr_hit && paddr == `ARE_OFF_RCSC)
            begin
                serial_port_enable_ff  <= pwdata[`ARE_RC_SERIAL_PORT_ENABLE];
                rx9_ff   <= pwdata[`ARE_RC_RX9];
                single_rx_enable_ff  <= pwdata[`ARE_RC_SINGLE_RX_ENABLE];
                continuous_rx_enable_ff  <= pwdata[`ARE_RC_CONTINUOUS_RX_ENABLE];
                addr_detect_enable_ff <= pwdata[`ARE_RC_ADDR_DETECT_ENABLE];
            end
            if (wr_hit && paddr == `ARE_OFF_IRQ)
                rx_char_irq_enable_ff <= pwdata[`ARE_IRQ_EN];
        end
    end

    assign rx_irq         = rx_char_flag && rx_char_irq_enable_ff;                      // [R6] [R15]
    assign sync_mode      = sync_ff;                                      // [R17]
    assign clk_master_sel = sync_ff && clock_source_select_ff;                           // [R21]
    assign tx_enable_eff  = transmit_enable_ff && !(sync_ff && (continuous_rx_enable_ff || single_rx_enable_ff)); // [R22]
    assign pins_to_port   = serial_port_enable_ff;                                      // [R24]
    assign tx_oe_n        = !serial_port_enable_ff;

    // Oversample tick; low speed is a longer divide, sync ignores the bit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_cnt_ff <= 16'h0000;
        else if (urst || div_cnt_ff == ((high_baud_select_ff || sync_ff) ? DIV_HI : DIV_LO)) // [R20]
            div_cnt_ff <= 16'h0000;
        else
            div_cnt_ff <= div_cnt_ff + 16'h0001;
    end

    assign tick = !urst && (div_cnt_ff == ((high_baud_select_ff || sync_ff) ? DIV_HI : DIV_LO));

    // Pin synchroniser; level changes once stages two and three agree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_s1_ff  <= 1'b1;
            rx_s2_ff  <= 1'b1;
            rx_s3_ff  <= 1'b1;
            rx_lvl_ff <= 1'b1;
        end
        else
        begin
            rx_s1_ff <= rx_pin;
            rx_s2_ff <= rx_s1_ff;
            rx_s3_ff <= rx_s2_ff;
            if (rx_s2_ff == rx_s3_ff)
                rx_lvl_ff <= rx_s3_ff;
        end
    end

    // Overrun blocks the receiver entirely, even address filtering
    assign rx_go     = serial_port_enable_ff && continuous_rx_enable_ff && !overrun_err_flag_ff && !sync_ff;          // [R8]
    assign bit_val   = (ones_ff + {1'b0, rx_lvl_ff}) >= 2'd2;
    assign stop_done = tick && rx_st_ff == RX_STOP && os_cnt_ff == `ARE_OVS_LAST;
    assign char_new  = rx9_ff ? shreg_ff : {1'b0, shreg_ff[8:1]};         // [R10]
    assign accept    = !(addr_detect_enable_ff && rx9_ff) || char_new[8];              // [R12] [R13]
    assign push      = stop_done && accept && (cnt_ff < 2'd2);            // [R3]
    assign ovr_set   = stop_done && accept && (cnt_ff == 2'd2);           // [R7]

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_st_ff   <= RX_IDLE;
            os_cnt_ff  <= 4'h0;
            bit_idx_ff <= 4'h0;
            ones_ff    <= 2'h0;
            shreg_ff   <= 9'h000;
        end
        else if (!rx_go)
        begin
            rx_st_ff  <= RX_IDLE;
            os_cnt_ff <= 4'h0;
        end
        else if (tick)
        begin
            os_cnt_ff <= os_cnt_ff + 4'h1;
            if (os_cnt_ff >= `ARE_OVS_MAJ0 && os_cnt_ff != `ARE_OVS_LAST)
                ones_ff <= ones_ff + {1'b0, rx_lvl_ff};
            case (rx_st_ff)
                RX_IDLE:
                begin
                    os_cnt_ff <= 4'h0;
                    if (!rx_lvl_ff)
                        rx_st_ff <= RX_START;
                end
                RX_START:
                begin
                    // False start aborts silently
                    if (os_cnt_ff == `ARE_OVS_HALF)
                    begin
                        os_cnt_ff  <= 4'h0;
                        ones_ff    <= 2'h0;
                        bit_idx_ff <= 4'h0;
                        rx_st_ff   <= rx_lvl_ff ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA:
                begin
                    if (os_cnt_ff == `ARE_OVS_LAST)
                    begin
                        ones_ff    <= 2'h0;
                        shreg_ff   <= {bit_val, shreg_ff[8:1]};
                        bit_idx_ff <= bit_idx_ff + 4'h1;
                        if (bit_idx_ff == (rx9_ff ? 4'h8 : 4'h7))         // [R10]
                            rx_st_ff <= RX_STOP;
                    end
                end
                RX_STOP:
                begin
                    if (os_cnt_ff == `ARE_OVS_LAST)
                    begin
                        ones_ff  <= 2'h0;
                        rx_st_ff <= RX_IDLE;
                    end
                end
                default: rx_st_ff <= RX_IDLE;
            endcase
        end
    end

    // Two-entry FIFO; each entry keeps framing flag, ninth bit and data
    generate
        for (genvar e = 0; e < `ARE_FIFO_DEPTH; e++)
        begin : g_entry
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    mem_ff[e] <= 10'h000;
                else if (push && wr_ptr_ff == 1'(e))
                    mem_ff[e] <= {!bit_val, char_new};                    // [R1] [R23]
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            cnt_ff    <= 2'd0;
        end
        else if (urst)
        begin
            wr_ptr_ff <= 1'b0;                                            // [R26]
            rd_ptr_ff <= 1'b0;
            cnt_ff    <= 2'd0;                                            // [R5]
        end
        else
        begin
            if (push)
                wr_ptr_ff <= !wr_ptr_ff;
            if (rd_pop)
                rd_ptr_ff <= !rd_ptr_ff;                                  // [R4]
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, rd_pop};
        end
    end

    // Port disable wins over set; set wins over the receive-enable clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            overrun_err_flag_ff <= 1'b0;
        else if (urst)
            overrun_err_flag_ff <= 1'b0;                                              // [R9]
        else if (ovr_set)
            overrun_err_flag_ff <= 1'b1;                                              // [R7]
        else if (!continuous_rx_enable_ff)
            overrun_err_flag_ff <= 1'b0;                                              // [R9]
    end

    // Break: thirteen low bit times then one stop bit
    assign brk_done = tick && tx_st_ff == TX_STOPBIT && tos_ff == `ARE_OVS_LAST;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_st_ff <= TX_IDLE;
            tos_ff   <= 4'h0;
            tbits_ff <= 4'h0;
            tx_out   <= 1'b1;
        end
        else if (urst)
        begin
            tx_st_ff <= TX_IDLE;
            tx_out   <= 1'b1;
        end
        else if (tick)
        begin
            tos_ff <= tos_ff + 4'h1;
            case (tx_st_ff)
                TX_IDLE:
                begin
                    tos_ff   <= 4'h0;
                    tbits_ff <= 4'h0;
                    if (brk_ff && transmit_enable_ff && !sync_ff)                    // [R18]
                    begin
                        tx_st_ff <= TX_BRK;
                        tx_out   <= 1'b0;
                    end
                end
                TX_BRK:
                begin
                    if (tos_ff == `ARE_OVS_LAST)
                    begin
                        tbits_ff <= tbits_ff + 4'h1;
                        if (tbits_ff == `ARE_BRK_BITS - 4'h1)
                        begin
                            tx_st_ff <= TX_STOPBIT;
                            tx_out   <= 1'b1;
                        end
                    end
                end
                TX_STOPBIT:
                begin
                    if (tos_ff == `ARE_OVS_LAST)
                        tx_st_ff <= TX_IDLE;
                end
                default: tx_st_ff <= TX_IDLE;
            endcase
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_full_arrival;
        stop_done && accept && cnt_ff == 2'd2;
    endsequence

    // Enables must stay up in the first cycle too, else the clear is legal
    sequence s_blocked;
        overrun_err_flag_ff && cnt_ff == 2'd2 && continuous_rx_enable_ff && serial_port_enable_ff;
    endsequence

    AST_FIFO_BOUND: assert property (cnt_ff <= 2'd2)                      // [R7]
        else $error("receive fifo count above two");

    AST_OVR_SET: assert property (s_full_arrival |=> overrun_err_flag_ff && cnt_ff == 2'd2) // [R7]
        else $error("overrun not flagged on third character");

    AST_OVR_BLOCK: assert property (overrun_err_flag_ff && continuous_rx_enable_ff |=> cnt_ff <= $past(cnt_ff)) // [R8]
        else $error("fifo grew while overrun set");

    AST_OVR_HOLD: assert property (s_blocked ##1 (continuous_rx_enable_ff && serial_port_enable_ff) |-> overrun_err_flag_ff) // [R9]
        else $error("overrun cleared without enable drop");

    AST_POP_NEXT: assert property (rd_pop && cnt_ff == 2'd2 |=>
        frame_err_flag == $past(mem_ff[!rd_ptr_ff][9]))                   // [R4]
        else $error("framing flag of next character not shown");

    AST_DISABLE: assert property (!serial_port_enable_ff |=> cnt_ff == 2'd0 && !overrun_err_flag_ff && !frame_err_flag) // [R5]
        else $error("port disable left receive state");

    AST_CONTINUOUS_RX_ENABLE_FRAME_ERR_FLAG: assert property ($fell(continuous_rx_enable_ff) && serial_port_enable_ff && !rd_pop && !$past(push) |->
        frame_err_flag == $past(frame_err_flag))                          // [R5]
        else $error("receive enable drop changed framing flag");

    AST_ADDR_DROP: assert property (stop_done && addr_detect_enable_ff && rx9_ff && !char_new[8] |=>
        cnt_ff <= $past(cnt_ff) && !$rose(overrun_err_flag_ff))                       // [R13]
        else $error("non-address character stored");

    AST_FLAG_SET: assert property (push |=> rx_char_flag ##0 (rx_irq == rx_char_irq_enable_ff)) // [R15]
        else $error("receive flag or interrupt missing after load");

    AST_TX_SHIFT_EMPTY_BRK: assert property (brk_ff && transmit_enable_ff && !sync_ff && tick &&
        tx_st_ff == TX_IDLE |=> !txsc_rd[`ARE_TX_TX_SHIFT_EMPTY] && !tx_out)         // [R19]
        else $error("break start not reflected on pin or status");

endmodule : are_serial_rx

// ### testbench/are_line_tx.sv
// Remote serial transmitter that drives the receive line of the unit
`timescale 1ns/1ps

module are_line_tx
#(
    parameter int BIT_CYC = 16
)
(
    input  wire logic clk,
    output logic      line
);

    // Idle level is high: the line is pulled up whenever no frame is sent
    initial line = 1'b1;

    // Start bit, data bits LSB first, then the chosen stop level
    task automatic send(input logic [8:0] val, input int nbits, input logic stop_lvl);
        int i;
        for (i = 0; i < nbits + 2; i++)
        begin
            if (i == 0)
                line <= 1'b0;
            else if (i <= nbits)
                line <= val[i-1];
            else
                line <= stop_lvl;
            repeat (BIT_CYC) @(posedge clk);
        end
        line <= 1'b1;
        repeat (2 * BIT_CYC) @(posedge clk);
    endtask : send

endmodule : are_line_tx

// ### testbench/test_are_serial_rx.sv
// Register-level tests of the serial receiver status and error handling
`timescale 1ns/1ps

module test_are_serial_rx;
    import are_pkg::*;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rx_pin;
    logic        tx_out;
    logic        tx_oe_n;
    logic        pins_to_port;
    logic        sync_mode;
    logic        clk_master_sel;
    logic        tx_enable_eff;
    logic        rx_irq;
    int          fails;
    int          checks_done;
    logic [31:0] rv;
    logic        err_v;
    int          k;

    // Divider of one keeps every high-baud bit at 16 clocks so the run stays short
    are_serial_rx #(.BAUD_DIV(1)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin), .tx_out(tx_out),
        .tx_oe_n(tx_oe_n), .pins_to_port(pins_to_port), .sync_mode(sync_mode),
        .clk_master_sel(clk_master_sel), .tx_enable_eff(tx_enable_eff), .rx_irq(rx_irq)
    );

    are_line_tx #(.BIT_CYC(16)) peer (.clk(pclk), .line(rx_pin));

    initial pclk = 1'b0;
    always #20 pclk = ~pclk;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic conclude;
        $display("Checks made %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude

    // One APB transfer; held until pready is seen high, then one idle edge
    task automatic xfer(input logic wr_en, input logic [7:0] addr, input logic [31:0] wd,
                        output logic [31:0] rd_v, output logic err);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr_en;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            check("pready wait", 32'h0000_0000, 32'h0000_0001);
        rd_v = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer

    task automatic wr(input logic [7:0] addr, input logic [7:0] val);
        logic [31:0] d;
        logic        e;
        xfer(1'b1, addr, {24'h00_0000, val}, d, e);
    endtask : wr

    // Unmapped offsets read here lie above the interrupt register
    task automatic rd(input logic [7:0] addr, input logic [31:0] exp,
                      input logic [31:0] msk = 32'hFFFF_FFFF);
        logic [31:0] d;
        logic        e;
        xfer(1'b0, addr, 32'h0000_0000, d, e);
        check($sformatf("reg %h", addr), d & msk, exp & msk);
        check($sformatf("pslverr %h", addr), {31'h0, e}, {31'h0, addr > 8'h0C});
    endtask : rd

    task automatic test_end(input string name);
        $display("Test %s done, mismatches so far %0d", name, fails);
    endtask : test_end

    initial
    begin
        fails = 0;
        checks_done = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(8'h00, 32'h0000_0002);
        rd(8'h04, 32'h0000_0000, 32'h0000_00FE);
        rd(8'h0C, 32'h0000_0000);
        rd(8'h10, 32'h0000_0000);
        test_end("reset");
        wr(8'h00, 8'h04);
        wr(8'h04, 8'h90);
        wr(8'h0C, 8'h02);
        check("pins_to_port", {31'h0, pins_to_port}, 32'h0000_0001);
        check("tx_oe_n", {31'h0, tx_oe_n}, 32'h0000_0000);
        peer.send(9'h055, 8, 1'b1);
        peer.send(9'h0A3, 8, 1'b0);
        peer.send(9'h03C, 8, 1'b1);
        check("rx_irq", {31'h0, rx_irq}, 32'h0000_0001);
        rd(8'h04, 32'h0000_0092, 32'h0000_00FE);
        rd(8'h08, 32'h0000_0055);
        rd(8'h04, 32'h0000_0096, 32'h0000_00FE);
        rd(8'h08, 32'h0000_00A3);
        peer.send(9'h011, 8, 1'b1);
        rd(8'h0C, 32'h0000_0002);
        rd(8'h04, 32'h0000_0002, 32'h0000_0002);
        wr(8'h04, 8'h80);
        rd(8'h04, 32'h0000_0000, 32'h0000_0002);
        test_end("overrun");
        wr(8'h04, 8'h90);
        peer.send(9'h00F, 8, 1'b0);
        rd(8'h04, 32'h0000_0094, 32'h0000_00FE);
        wr(8'h04, 8'h80);
        rd(8'h04, 32'h0000_0084, 32'h0000_00FE);
        wr(8'h04, 8'h00);
        rd(8'h04, 32'h0000_0000, 32'h0000_00FE);
        rd(8'h0C, 32'h0000_0002);
        check("tx_oe_n off", {31'h0, tx_oe_n}, 32'h0000_0001);
        test_end("framing");
        wr(8'h04, 8'hD0);
        peer.send(9'h1AB, 9, 1'b1);
        rd(8'h04, 32'h0000_00D1);
        rd(8'h08, 32'h0000_00AB);
        wr(8'h04, 8'hD8);
        peer.send(9'h042, 9, 1'b1);
        rd(8'h0C, 32'h0000_0002);
        peer.send(9'h177, 9, 1'b1);
        rd(8'h04, 32'h0000_00D9);
        rd(8'h08, 32'h0000_0077);
        wr(8'h04, 8'hD0);
        peer.send(9'h033, 9, 1'b1);
        rd(8'h08, 32'h0000_0033);
        wr(8'h04, 8'hD8);
        rd(8'h04, 32'h0000_00D8);
        test_end("nine bit");
        wr(8'h00, 8'h2C);
        repeat (40) @(posedge pclk);
        check("tx_out break", {31'h0, tx_out}, 32'h0000_0000);
        rd(8'h00, 32'h0000_0008, 32'h0000_000A);
        k = 0;
        rv = 32'h0000_0008;
        while (rv[3] === 1'b1 && k < 150)
        begin
            xfer(1'b0, 8'h00, 32'h0000_0000, rv, err_v);
            k++;
        end
        rd(8'h00, 32'h0000_0026);
        check("tx_out idle", {31'h0, tx_out}, 32'h0000_0001);
        test_end("break");
        wr(8'h00, 8'hB4);
        wr(8'h04, 8'h90);
        check("sync_mode", {31'h0, sync_mode}, 32'h0000_0001);
        check("clk_master_sel", {31'h0, clk_master_sel}, 32'h0000_0001);
        check("tx_enable_eff", {31'h0, tx_enable_eff}, 32'h0000_0000);
        wr(8'h04, 8'h80);
        check("tx_enable_eff on", {31'h0, tx_enable_eff}, 32'h0000_0001);
        wr(8'h00, 8'hA4);
        check("async mode", {31'h0, sync_mode}, 32'h0000_0000);
        check("clk_master async", {31'h0, clk_master_sel}, 32'h0000_0000);
        test_end("modes");
        conclude();
    end

    // Tests need about 2200 clocks; the limit leaves ample margin
    initial
    begin
        repeat (20000) @(posedge pclk);
        fails++;
        conclude();
    end

endmodule : test_are_serial_rx
